// >>> core/sprh_core.sv
// serial parameter read handler: frame receive, read reply, tx buffer
`timescale 1ns/1ns
`include "sprh_consts.svh"
module sprh_core
	import sprh_pkg::*;
#(
	parameter int GAP_CYCLES = `SPRH_GAP_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// configuration
	input wire logic [7:0] station_id,
	// received bytes from the serial receiver
	input wire logic [7:0] rx_byte,
	input wire logic rx_valid,
	// reply bytes to the serial transmitter
	output logic [7:0] tx_byte,
	output logic tx_valid,
	input wire logic tx_ready,
	// parameter store read port
	output sprh_par_req_type par_req,
	input wire sprh_par_ans_type par_ans,
	// write frames handed to the write handler
	output logic write_seen,
	output logic [7:0] write_func
);
	function automatic logic [15:0] crc_step(input logic [15:0] c,
			input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `SPRH_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// idle gap timing
	logic [23:0] idle_cnt;
	logic [3:0] rx_cnt;
	logic [15:0] rx_crc;
	logic [7:0] rx_buf [0:5];
	sprh_req_type req;
	wire logic tx_moved = tx_valid & tx_ready;
	wire logic gap_ok = idle_cnt == 24'(GAP_CYCLES);
	wire logic gap_hit = idle_cnt == 24'(GAP_CYCLES - 1);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_cnt <= 24'h0000_0000;
		end else if (rx_valid || tx_moved) begin
			idle_cnt <= 24'h0000_0000;
		end else if (!gap_ok) begin
			idle_cnt <= idle_cnt + 24'h00_0001;
		end
	end

	// receive side
	wire logic frame_end = gap_hit && rx_cnt != 4'h0;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt <= 4'h0;
			rx_crc <= `SPRH_CRC_INIT;
		end else if (rx_valid) begin
			rx_crc <= crc_step(rx_crc, rx_byte);
			if (rx_cnt != 4'hF) begin
				rx_cnt <= rx_cnt + 4'h1;
			end
		end else if (frame_end) begin
			rx_cnt <= 4'h0;
			rx_crc <= `SPRH_CRC_INIT;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_rx_buf
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					rx_buf[gi] <= 8'h00;
				end else if (rx_valid && rx_cnt == 4'(gi)) begin
					rx_buf[gi] <= rx_byte;
				end
			end
		end
	endgenerate

	assign req.station = rx_buf[0];
	assign req.func = rx_buf[1];
	assign req.start_addr = {rx_buf[2], rx_buf[3]};
	assign req.word_count = {rx_buf[4], rx_buf[5]};

	// frame qualification
	// residue over data plus its check is zero when intact
	wire logic crc_ok = rx_crc == 16'h0000 && rx_cnt >= `SPRH_MIN_LEN;
	wire logic id_ok = station_id >= `SPRH_STATION_MIN &&
		station_id <= `SPRH_STATION_MAX;
	wire logic take = frame_end && crc_ok && id_ok &&
		req.station == station_id;
	wire logic is_read = req.func == `SPRH_FUNC_READ;
	wire logic is_write = req.func == `SPRH_FUNC_WR16 ||
		req.func == `SPRH_FUNC_WR32;
	wire logic count_ok = rx_cnt == `SPRH_REQ_LEN &&
		req.word_count != 16'h0000 &&
		req.word_count <= `SPRH_MAX_WORDS;

	// two-entry reply buffer
	logic [7:0] tail;
	logic tail_valid;
	logic push;
	logic [7:0] push_byte;
	wire logic buf_ready = ~tail_valid;
	wire logic buf_empty = ~tx_valid & ~tail_valid;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_byte <= 8'h00;
			tx_valid <= 1'b0;
			tail <= 8'h00;
			tail_valid <= 1'b0;
		end else begin
			if (!tx_valid || tx_ready) begin
				tx_valid <= tail_valid | push;
				tx_byte <= tail_valid ? tail : push_byte;
				tail_valid <= tail_valid & push;
				tail <= push_byte;
			end else if (push) begin
				tail_valid <= 1'b1;
				tail <= push_byte;
			end
		end
	end

	// reply sequencer
	sprh_state_type state;
	sprh_state_type next_state;
	logic [7:0] rep_func;
	logic [7:0] exc_code;
	logic exc;
	logic hdr_done;
	logic [15:0] words_left;
	logic [15:0] word_hold;
	logic [15:0] tx_crc;
	logic [7:0] byte_count;

	always_comb begin
		push = 1'b0;
		push_byte = 8'h00;
		next_state = state;
		unique case (state)
			ST_IDLE, ST_WAIT: begin
			end
			ST_ADDR: begin
				push_byte = station_id;
				next_state = ST_FUNC;
			end
			ST_FUNC: begin
				push_byte = rep_func | (exc ? `SPRH_EXC_FLAG : 8'h00);
				next_state = exc ? ST_EXC : ST_CNT;
			end
			ST_CNT: begin
				push_byte = byte_count;
				next_state = ST_HI;
			end
			ST_EXC: begin
				push_byte = exc_code;
				next_state = ST_CHK_LO;
			end
			ST_HI: begin
				push_byte = word_hold[15:8];
				next_state = ST_LO;
			end
			ST_LO: begin
				push_byte = word_hold[7:0];
				next_state = words_left == 16'h0001 ? ST_CHK_LO : ST_WAIT;
			end
			ST_CHK_LO: begin
				push_byte = tx_crc[7:0];
				next_state = ST_CHK_HI;
			end
			ST_CHK_HI: begin
				push_byte = tx_crc[15:8];
				next_state = ST_GAP;
			end
			ST_GAP: begin
			end
		endcase
		if (state != ST_IDLE && state != ST_WAIT && state != ST_GAP) begin
			push = buf_ready;
			if (!buf_ready) begin
				next_state = state;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			rep_func <= 8'h00;
			exc_code <= 8'h00;
			exc <= 1'b0;
			hdr_done <= 1'b0;
			words_left <= 16'h0000;
			word_hold <= 16'h0000;
			byte_count <= 8'h00;
			par_req <= '0;
			write_seen <= 1'b0;
			write_func <= 8'h00;
		end else begin
			state <= next_state;
			par_req.valid <= 1'b0;
			write_seen <= 1'b0;
			if (state == ST_IDLE && take) begin
				rep_func <= req.func;
				hdr_done <= 1'b0;
				words_left <= req.word_count;
				byte_count <= {req.word_count[6:0], 1'b0};
				if (is_write) begin
					write_seen <= 1'b1;
					write_func <= req.func;
				end else if (is_read && count_ok) begin
					exc <= 1'b0;
					par_req.valid <= 1'b1;
					par_req.addr <= req.start_addr;
					state <= ST_WAIT;
				end else begin
					exc <= 1'b1;
					exc_code <= is_read ? `SPRH_EXC_COUNT : `SPRH_EXC_FUNC;
					state <= ST_ADDR;
				end
			end
			if (state == ST_WAIT && par_ans.ack) begin
				word_hold <= par_ans.data;
				hdr_done <= 1'b1;
				if (!hdr_done && par_ans.err) begin
					exc <= 1'b1;
					exc_code <= `SPRH_EXC_PARAM;
				end
				state <= hdr_done ? ST_HI : ST_ADDR;
			end
			if (state == ST_LO && push && words_left != 16'h0001) begin
				words_left <= words_left - 16'h0001;
				par_req.valid <= 1'b1;
				par_req.addr <= par_req.addr + 16'h0001;
			end
			if (state == ST_GAP && buf_empty && gap_ok) begin
				state <= ST_IDLE;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_crc <= `SPRH_CRC_INIT;
		end else if (state == ST_IDLE) begin
			tx_crc <= `SPRH_CRC_INIT;
		end else if (push && state != ST_CHK_LO && state != ST_CHK_HI) begin
			tx_crc <= crc_step(tx_crc, push_byte);
		end
	end
endmodule

// >>> pkg/sprh_consts.svh
// constants of the serial parameter read handler
`ifndef SPRH_CONSTS_SVH
`define SPRH_CONSTS_SVH
`define SPRH_FUNC_READ 8'h03
`define SPRH_FUNC_WR16 8'h06
`define SPRH_FUNC_WR32 8'h10
`define SPRH_EXC_FLAG 8'h80
`define SPRH_STATION_MIN 8'h01
`define SPRH_STATION_MAX 8'hF7
`define SPRH_CRC_INIT 16'hFFFF
`define SPRH_CRC_POLY 16'hA001
`define SPRH_MAX_WORDS 16'h007D
`define SPRH_EXC_FUNC 8'h01
`define SPRH_EXC_PARAM 8'h02
`define SPRH_EXC_COUNT 8'h03
`define SPRH_REQ_LEN 4'h8
`define SPRH_MIN_LEN 4'h4
`define SPRH_CLK_NS 20
`define SPRH_CHAR_NS 572917
`define SPRH_GAP_CYC ((`SPRH_CHAR_NS * 7 + 2 * `SPRH_CLK_NS - 1) / (2 * `SPRH_CLK_NS))
`endif

// >>> pkg/sprh_pkg.sv
// types of the serial parameter read handler
package sprh_pkg;
	typedef struct packed {
		logic [7:0] station;
		logic [7:0] func;
		logic [15:0] start_addr;
		logic [15:0] word_count;
	} sprh_req_type;

	typedef struct packed {
		logic [15:0] addr;
		logic valid;
	} sprh_par_req_type;

	typedef struct packed {
		logic [15:0] data;
		logic err;
		logic ack;
	} sprh_par_ans_type;

	typedef enum logic [3:0] {
		ST_IDLE, ST_WAIT, ST_ADDR, ST_FUNC, ST_CNT, ST_EXC,
		ST_HI, ST_LO, ST_CHK_LO, ST_CHK_HI, ST_GAP
	} sprh_state_type;
endpackage

// >>> testbench/sprh_core_monitor.sv
// port assertions of the parameter read handler
`timescale 1ns/1ns
module sprh_core_monitor
	import sprh_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// inputs
	input wire logic [7:0] station_id,
	input wire logic rx_valid,
	input wire logic tx_ready,
	// outputs
	input wire logic [7:0] tx_byte,
	input wire logic tx_valid,
	input wire sprh_par_req_type par_req,
	input wire logic write_seen,
	input wire logic [7:0] write_func
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_wr_pulse; write_seen |=> !write_seen; endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("pulse");
	property p_wr_func;
		write_seen |-> write_func == 8'h06 || write_func == 8'h10;
	endproperty
	a_wr_func: assert property (p_wr_func) else $error("wfunc");
	property p_tx_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("hold");
	property p_req_pulse; par_req.valid |=> !par_req.valid; endproperty
	a_req_pulse: assert property (p_req_pulse) else $error("req");
	property p_addr_hold; !par_req.valid |-> $stable(par_req.addr); endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("addr");
	property p_bad_stn;
		(station_id == 8'h00 || station_id > 8'hF7) && !tx_valid |=> !tx_valid;
	endproperty
	a_bad_stn: assert property (p_bad_stn) else $error("stn");
	property p_gap; rx_valid && !tx_valid |=> !tx_valid [*8]; endproperty
	a_gap: assert property (p_gap) else $error("gap");
	property p_req_gap; rx_valid |=> !par_req.valid [*8]; endproperty
	a_req_gap: assert property (p_req_gap) else $error("rgap");
endmodule
bind sprh_core sprh_core_monitor sprh_core_monitor_i (.ref_clk(ref_clk),
	.rst_n(rst_n), .station_id(station_id), .rx_valid(rx_valid),
	.tx_ready(tx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid),
	.par_req(par_req), .write_seen(write_seen), .write_func(write_func));

// >>> testbench/sprh_store.sv
// parameter store model with chosen answer delay
`timescale 1ns/1ns
module sprh_store
	import sprh_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// read port
	input wire sprh_par_req_type par_req,
	output sprh_par_ans_type par_ans,
	// delay and failing address
	input wire logic [3:0] delay,
	input wire logic [15:0] bad_addr
);
	logic [3:0] cnt;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
			par_ans <= '0;
		end else begin
			// one word per address, garbage between answers
			par_ans.ack <= cnt == 4'h1;
			par_ans.data <= cnt == 4'h1 ? par_req.addr ^ 16'hA5C3
				: ~par_ans.data;
			par_ans.err <= cnt == 4'h1 && par_req.addr == bad_addr;
			if (par_req.valid)
				cnt <= delay + 4'h1;
			else if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
	end
endmodule

// >>> testbench/sprh_core_tb.sv
// self-checking bench of the parameter read handler
`timescale 1ns/1ns
module sprh_core_tb
	import sprh_pkg::*;
;
	logic ref_clk = 0, rst_n = 0, rx_valid = 0, tx_ready = 0;
	logic tx_valid, write_seen, ws;
	logic [7:0] station_id = 8'hF7, rx_byte = 0, tx_byte, write_func;
	logic [3:0] delay = 0;
	logic [15:0] bad_addr = 16'hFFFF;
	sprh_par_req_type par_req;
	sprh_par_ans_type par_ans;
	int error_cnt = 0, n_tests = 0;
	logic [7:0] q[$], e[$];
	sprh_core #(.GAP_CYCLES(20)) sprh_core_i (.ref_clk(ref_clk),
		.rst_n(rst_n), .station_id(station_id), .rx_byte(rx_byte),
		.rx_valid(rx_valid), .tx_byte(tx_byte), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .par_req(par_req), .par_ans(par_ans),
		.write_seen(write_seen), .write_func(write_func));
	sprh_store sprh_store_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.par_req(par_req), .par_ans(par_ans), .delay(delay),
		.bad_addr(bad_addr));
	initial forever #10 ref_clk = ~ref_clk;
	function automatic logic [15:0] crc(logic [7:0] b[$]);
		logic [15:0] c = 16'hFFFF;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction
	task summarize();
		$display("errors %0d tests %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(logic [7:0] g, logic [7:0] x);
		n_tests++;
		if (g !== x) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask
	// send with check, then collect reply under random stalls
	task frame(logic [7:0] f[$], logic good);
		logic [15:0] c;
		int idle;
		c = crc(f) ^ {16{!good}};
		f = {f, c[7:0], c[15:8]};
		q = {};
		ws = 0;
		idle = 0;
		foreach (f[i]) begin
			@(negedge ref_clk) rx_byte = f[i];
			rx_valid = 1;
			@(negedge ref_clk) rx_valid = 0;
		end
		for (int k = 0; k < 4000 && idle < 80; k++) begin
			@(negedge ref_clk) tx_ready = $urandom % 3 != 0;
			ws |= write_seen;
			idle++;
			if (tx_valid && tx_ready) begin
				q.push_back(tx_byte);
				idle = 0;
			end
		end
		if (idle < 80) begin
			error_cnt++;
			$display("[ERR] %0t reply did not finish", $time);
			summarize();
		end
	endtask
	task cmp();
		logic [15:0] c;
		c = crc(e);
		if (e.size() > 0)
			e = {e, c[7:0], c[15:8]};
		chk(8'(q.size()), 8'(e.size()));
		foreach (e[i]) chk(q[i], e[i]);
	endtask
	initial begin
		logic [15:0] a, d;
		logic [7:0] n;
		static logic [7:0] xf[4] = '{8'h04, 8'h03, 8'h03, 8'h03};
		static logic [7:0] xn[4] = '{8'h01, 8'h00, 8'h7E, 8'h01};
		static logic [7:0] xc[4] = '{8'h01, 8'h03, 8'h03, 8'h02};
		void'($urandom(73));
		repeat (6) @(negedge ref_clk);
		rst_n = 1;
		repeat (6) begin
			// keep clear of the failing address of the store
			a = $urandom % 16'hFFFF;
			n = 8'h01 + $urandom % 4;
			delay = $urandom % 9;
			e = {station_id, 8'h03, 8'(n * 2)};
			for (int i = 0; i < n; i++) begin
				d = (a + i) ^ 16'hA5C3;
				e = {e, d[15:8], d[7:0]};
			end
			frame({station_id, 8'h03, a[15:8], a[7:0], 8'h00, n}, 1);
			cmp();
		end
		for (int k = 0; k < 4; k++) begin
			bad_addr = k == 3 ? a : 16'hFFFF;
			frame({station_id, xf[k], a[15:8], a[7:0], 8'h00, xn[k]}, 1);
			e = {station_id, xf[k] | 8'h80, xc[k]};
			cmp();
		end
		// read frame too short for address and count
		frame({station_id, 8'h03}, 1);
		e = {station_id, 8'h83, 8'h03};
		cmp();
		frame({station_id, 8'h03, a[15:8], a[7:0], 8'h00, 8'h01}, 0);
		e = {};
		cmp();
		frame({8'h01, 8'h03, a[15:8], a[7:0], 8'h00, 8'h01}, 1);
		cmp();
		foreach (xc[k]) begin
			n = k[0] ? 8'h10 : 8'h06;
			frame({station_id, n, a[15:8], a[7:0], 8'h00, 8'h01}, 1);
			chk({7'h00, ws}, 8'h01);
			chk(write_func, n);
			cmp();
		end
		station_id = 8'h00;
		frame({8'h00, 8'h03, a[15:8], a[7:0], 8'h00, 8'h01}, 1);
		cmp();
		summarize();
	end
endmodule
